// >>> design/sleep_output_defines.svh
`ifndef SLEEP_OUTPUT_DEFINES_SVH
`define SLEEP_OUTPUT_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define OFS_SLEEP_PROFILE_CONFIG 8'h12
`define OFS_DATA_OUTPUT_CONFIG   8'h13
`define OFS_DATA_X_LOW           8'h02
`define OFS_DATA_X_HIGH          8'h03
`define OFS_DATA_Y_LOW           8'h04
`define OFS_DATA_Y_HIGH          8'h05
`define OFS_DATA_Z_LOW           8'h06
`define OFS_DATA_Z_HIGH          8'h07
`define OFS_STATUS               8'h20

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define BIT_PROFILE_SELECT       6
`define BIT_TIMEBASE_SELECT      5
`define BIT_UNFILTERED_SELECT    7
`define BIT_LOCK_DISABLE         6
`define RST_SLEEP_PROFILE_CONFIG 8'h00
`define RST_DATA_OUTPUT_CONFIG   8'h00
`define MASK_SLEEP_PROFILE       8'h60
`define MASK_DATA_OUTPUT         8'hC0

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLOCK_PERIOD_NS          100
`define SLOW_WRITE_GAP_NS        400
`define SLOW_WRITE_GAP_CYCLES    ((`SLOW_WRITE_GAP_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define SAMPLE_PERIOD_CYCLES     16

`endif

// >>> design/sleep_output_pkg.sv
package sleep_output_pkg;

    typedef enum logic {
        DEEP_SAVING_PROFILE,
        LIGHT_SAVING_PROFILE
    } profile_t;

    typedef enum logic [1:0] {
        RUN_FULL,
        RUN_DUTY_CYCLED,
        RUN_HALTED
    } run_state_t;

endpackage

// >>> design/axis_lock_if.sv
`timescale 1ns/1ps
interface axis_lock_if;
    logic        lock_enable;
    logic        sample_valid;
    logic [15:0] sample;
    logic        low_read;
    logic        high_read;
    logic [7:0]  low_byte;
    logic [7:0]  high_byte;

    modport owner (
        output lock_enable,
        output sample_valid,
        output sample,
        output low_read,
        output high_read,
        input  low_byte,
        input  high_byte
    );

    modport lock (
        input  lock_enable,
        input  sample_valid,
        input  sample,
        input  low_read,
        input  high_read,
        output low_byte,
        output high_byte
    );
endinterface

// >>> design/axis_read_lock.sv
`timescale 1ns/1ps
module axis_read_lock (
    input  wire logic   clock_in,
    input  wire logic   nrst_in,
    axis_lock_if.lock   port
);
    logic [7:0] low_reg;
    logic [7:0] low_next;
    logic [7:0] high_reg;
    logic [7:0] high_next;
    logic       frozen_reg;
    logic       frozen_next;

    // ------------------------------------------------------------------
    // Freeze of the high byte between a low read and a high read.
    // ------------------------------------------------------------------
    always_comb begin
        low_next    = low_reg;
        high_next   = high_reg;
        frozen_next = frozen_reg;
        if (!port.lock_enable) begin
            frozen_next = 1'b0;
        end else if (port.low_read) begin
            frozen_next = 1'b1;
        end else if (port.high_read) begin
            frozen_next = 1'b0;
        end
        if (port.sample_valid) begin
            low_next = port.sample[7:0];
            if (!frozen_next) begin
                high_next = port.sample[15:8];
            end
        end
    end

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            low_reg    <= 8'h00;
            high_reg   <= 8'h00;
            frozen_reg <= 1'b0;
        end else begin
            low_reg    <= low_next;
            high_reg   <= high_next;
            frozen_reg <= frozen_next;
        end
    end

    assign port.low_byte  = low_reg;
    assign port.high_byte = high_reg;

    AST_HIGH_HELD: assert property (@(posedge clock_in) disable iff (!nrst_in)
        frozen_reg && port.lock_enable && !port.high_read |=> $stable(high_reg))
        else $error("High byte changed while frozen.");
    AST_RELEASE: assert property (@(posedge clock_in) disable iff (!nrst_in)
        port.lock_enable && port.high_read && !port.low_read |=> !frozen_reg)
        else $error("Lock not released after high read.");
endmodule

// >>> design/sample_pacer.sv
`timescale 1ns/1ps
`include "sleep_output_defines.svh"
module sample_pacer #(
    parameter int PERIOD = `SAMPLE_PERIOD_CYCLES
) (
    input  wire logic clock_in,
    input  wire logic nrst_in,
    input  wire logic duty_cycled_in,
    input  wire logic equidistant_in,
    input  wire logic event_in,
    output logic      take_out
);
    logic [15:0] count_reg;
    logic [15:0] count_next;
    logic        take_next;

    // ------------------------------------------------------------------
    // Wake-up spacing for the duty-cycled state.
    // ------------------------------------------------------------------
    always_comb begin
        count_next = count_reg;
        take_next  = 1'b0;
        if (!duty_cycled_in) begin
            count_next = 16'h0000;
            take_next  = event_in;
        end else if (equidistant_in) begin
            if (count_reg == 16'(PERIOD - 1)) begin
                count_next = 16'h0000;
                take_next  = 1'b1;
            end else begin
                count_next = count_reg + 16'h0001;
            end
        end else begin
            count_next = 16'h0000;
            take_next  = event_in;
        end
    end

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            count_reg <= 16'h0000;
            take_out  <= 1'b0;
        end else begin
            count_reg <= count_next;
            take_out  <= take_next;
        end
    end

    AST_EQUIDISTANT: assert property (@(posedge clock_in) disable iff (!nrst_in)
        duty_cycled_in && equidistant_in && count_reg == 16'(PERIOD - 1) |=> take_out)
        else $error("Equidistant sample missed.");
endmodule

// >>> design/sleep_output_regs.sv
`timescale 1ns/1ps
`include "sleep_output_defines.svh"
// Operation
// - Deep profile lowers halted and duty power further and blocks FIFO access while halted or duty-cycled.
// - Light profile keeps FIFO reachable and takes writes at full speed.
// - Light profile duty-cycled power stays below full-run power.
// - Time-base bit 0 spaces duty-cycled wake-ups by events.
// - Time-base bit 1 samples at equal intervals while duty-cycled.
// - Evenly spaced FIFO entry guaranteed only under equidistant time base.
// - Output bit 1 gives unfiltered data, 0 gives filtered data.
// - Lock-disable bit 1 turns read-out lock off, 0 turns it on.
// - With lock on, low-byte read freezes that axis high byte.
// - With lock on, high-byte read releases the frozen high byte.
module sleep_output_regs #(
    parameter int SAMPLE_PERIOD = `SAMPLE_PERIOD_CYCLES,
    parameter int WRITE_GAP     = `SLOW_WRITE_GAP_CYCLES
) (
    input  wire logic        clock_in,
    input  wire logic        nrst_in,
    input  wire logic [7:0]  addr_in,
    input  wire logic [7:0]  wdata_in,
    input  wire logic        write_in,
    input  wire logic        read_in,
    output logic      [7:0]  rdata_out,
    input  wire logic [1:0]  run_state_in,
    input  wire logic        sample_event_in,
    input  wire logic [47:0] filtered_in,
    input  wire logic [47:0] unfiltered_in,
    input  wire logic        fifo_request_in,
    output logic             fifo_enable_out,
    output logic             deep_power_cut_out,
    output logic             duty_power_cut_out,
    output logic             sample_take_out,
    output logic             write_dropped_out
);
    logic [7:0]  profile_reg;
    logic [7:0]  profile_next;
    logic [7:0]  output_reg;
    logic [7:0]  output_next;
    logic [7:0]  rdata_next;
    logic [7:0]  gap_reg;
    logic [7:0]  gap_next;
    logic        dropped_reg;
    logic        dropped_next;
    logic        fifo_next;
    logic        deep_cut_next;
    logic        duty_cut_next;
    logic        deep_sel;
    logic        duty_cycled;
    logic        halted;
    logic        write_ok;
    logic        take;
    logic [47:0] sample_sel;
    logic [2:0]  low_hit;
    logic [2:0]  high_hit;
    logic [7:0]  low_bytes  [3];
    logic [7:0]  high_bytes [3];
    logic [1:0]  rs_q1;
    logic [1:0]  rs_q2;
    logic [1:0]  rs_q3;
    logic [1:0]  rs_stable;
    logic [1:0]  rs_stable_next;

    default clocking @(posedge clock_in);
    endclocking
    default disable iff (!nrst_in);

    // ------------------------------------------------------------------
    // Run-state input synchroniser; a change counts when the last two stages agree.
    // ------------------------------------------------------------------
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rs_q1     <= 2'h0;
            rs_q2     <= 2'h0;
            rs_q3     <= 2'h0;
            rs_stable <= 2'h0;
        end else begin
            rs_q1 <= run_state_in;
            rs_q2 <= rs_q1;
            rs_q3 <= rs_q2;
            rs_stable <= rs_stable_next;
        end
    end

    always_comb begin
        rs_stable_next = rs_stable;
        if (rs_q2 == rs_q3) begin
            rs_stable_next = rs_q3;
        end
    end

    assign deep_sel    = profile_reg[`BIT_PROFILE_SELECT] ==
                         1'(sleep_output_pkg::DEEP_SAVING_PROFILE);
    assign duty_cycled = rs_stable == 2'(sleep_output_pkg::RUN_DUTY_CYCLED);
    assign halted      = rs_stable == 2'(sleep_output_pkg::RUN_HALTED);
    // Under the deep profile, while duty-cycled or halted, a write inside the gap after another is dropped.
    assign write_ok    = !(deep_sel && (duty_cycled || halted)) || gap_reg == 8'h00;

    // ------------------------------------------------------------------
    // Register file writes and write gap.
    // ------------------------------------------------------------------
    always_comb begin
        profile_next = profile_reg;
        output_next  = output_reg;
        gap_next     = (gap_reg != 8'h00) ? gap_reg - 8'h01 : 8'h00;
        dropped_next = 1'b0;
        if (write_in) begin
            if (write_ok) begin
                case (addr_in)
                    `OFS_SLEEP_PROFILE_CONFIG: begin
                        profile_next = wdata_in & `MASK_SLEEP_PROFILE;
                    end
                    `OFS_DATA_OUTPUT_CONFIG: begin
                        output_next = wdata_in & `MASK_DATA_OUTPUT;
                    end
                    default: begin
                    end
                endcase
                gap_next = 8'(WRITE_GAP - 1);
            end else begin
                dropped_next = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Read path; data stand for one cycle, then the bus returns to zero.
    // ------------------------------------------------------------------
    always_comb begin
        rdata_next = 8'h00;
        if (read_in) begin
            case (addr_in)
                `OFS_SLEEP_PROFILE_CONFIG: rdata_next = profile_reg;
                `OFS_DATA_OUTPUT_CONFIG:   rdata_next = output_reg;
                `OFS_DATA_X_LOW:           rdata_next = low_bytes[0];
                `OFS_DATA_X_HIGH:          rdata_next = high_bytes[0];
                `OFS_DATA_Y_LOW:           rdata_next = low_bytes[1];
                `OFS_DATA_Y_HIGH:          rdata_next = high_bytes[1];
                `OFS_DATA_Z_LOW:           rdata_next = low_bytes[2];
                `OFS_DATA_Z_HIGH:          rdata_next = high_bytes[2];
                `OFS_STATUS:               rdata_next = {5'h00, rs_stable, fifo_enable_out};
                default:                   rdata_next = 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Power and FIFO gating.
    // ------------------------------------------------------------------
    always_comb begin
        fifo_next     = fifo_request_in;
        deep_cut_next = 1'b0;
        duty_cut_next = duty_cycled;
        if ((duty_cycled || halted) && deep_sel) begin
            fifo_next     = 1'b0;
            deep_cut_next = 1'b1;
        end
    end

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            profile_reg        <= `RST_SLEEP_PROFILE_CONFIG;
            output_reg         <= `RST_DATA_OUTPUT_CONFIG;
            gap_reg            <= 8'h00;
            dropped_reg        <= 1'b0;
            rdata_out          <= 8'h00;
            fifo_enable_out    <= 1'b0;
            deep_power_cut_out <= 1'b0;
            duty_power_cut_out <= 1'b0;
        end else begin
            profile_reg        <= profile_next;
            output_reg         <= output_next;
            gap_reg            <= gap_next;
            dropped_reg        <= dropped_next;
            rdata_out          <= rdata_next;
            fifo_enable_out    <= fifo_next;
            deep_power_cut_out <= deep_cut_next;
            duty_power_cut_out <= duty_cut_next;
        end
    end

    assign write_dropped_out = dropped_reg;

    // ------------------------------------------------------------------
    // Sample pacing and per-axis read-out lock.
    // ------------------------------------------------------------------
    sample_pacer #(
        .PERIOD (SAMPLE_PERIOD)
    ) pacer (
        .clock_in       (clock_in),
        .nrst_in        (nrst_in),
        .duty_cycled_in (duty_cycled),
        .equidistant_in (profile_reg[`BIT_TIMEBASE_SELECT]),
        .event_in       (sample_event_in),
        .take_out       (take)
    );

    assign sample_take_out = take;
    assign sample_sel = output_reg[`BIT_UNFILTERED_SELECT] ? unfiltered_in : filtered_in;
    assign low_hit  = {read_in && addr_in == `OFS_DATA_Z_LOW,
                       read_in && addr_in == `OFS_DATA_Y_LOW,
                       read_in && addr_in == `OFS_DATA_X_LOW};
    assign high_hit = {read_in && addr_in == `OFS_DATA_Z_HIGH,
                       read_in && addr_in == `OFS_DATA_Y_HIGH,
                       read_in && addr_in == `OFS_DATA_X_HIGH};

    for (genvar a = 0; a < 3; a++) begin : g_axis
        axis_lock_if link ();
        assign link.lock_enable  = !output_reg[`BIT_LOCK_DISABLE];
        assign link.sample_valid = take;
        assign link.sample       = sample_sel[16*a +: 16];
        assign link.low_read     = low_hit[a];
        assign link.high_read    = high_hit[a];
        assign low_bytes[a]      = link.low_byte;
        assign high_bytes[a]     = link.high_byte;
        axis_read_lock lock (
            .clock_in (clock_in),
            .nrst_in  (nrst_in),
            .port     (link.lock)
        );
    end

    // ------------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------------
    AST_DEEP_FIFO_OFF: assert property (@(posedge clock_in) disable iff (!nrst_in)
        deep_sel && halted |=> !fifo_enable_out)
        else $error("FIFO reachable under deep profile.");
    AST_LIGHT_FIFO_ON: assert property (@(posedge clock_in) disable iff (!nrst_in)
        !deep_sel && fifo_request_in |=> fifo_enable_out)
        else $error("FIFO blocked under light profile.");
    AST_LIGHT_WRITE: assert property (@(posedge clock_in) disable iff (!nrst_in)
        !deep_sel && write_in && addr_in == `OFS_DATA_OUTPUT_CONFIG
        |=> output_reg == ($past(wdata_in) & `MASK_DATA_OUTPUT))
        else $error("Full-speed write lost.");
    AST_DUTY_CUT: assert property (@(posedge clock_in) disable iff (!nrst_in)
        duty_cycled |=> duty_power_cut_out)
        else $error("Duty power cut missing.");
    AST_RESERVED: assert property (@(posedge clock_in) disable iff (!nrst_in)
        (profile_reg & ~`MASK_SLEEP_PROFILE) == 8'h00)
        else $error("Reserved bits stored.");
    AST_READBACK: assert property (@(posedge clock_in) disable iff (!nrst_in)
        read_in && addr_in == `OFS_DATA_OUTPUT_CONFIG |=> rdata_out == $past(output_reg))
        else $error("Readback mismatch.");
    AST_EVENT_TB: assert property (@(posedge clock_in) disable iff (!nrst_in)
        duty_cycled && !profile_reg[`BIT_TIMEBASE_SELECT] && !sample_event_in |=> !take)
        else $error("Sample without event.");
    AST_UNMAPPED: assert property (@(posedge clock_in) disable iff (!nrst_in)
        read_in && addr_in == 8'hFF |=> rdata_out == 8'h00)
        else $error("Unmapped read not zero.");

    // ------------------------------------------------------------------
    // Profile, power and write-gap checks.
    // ------------------------------------------------------------------
    AST_DEEP_DUTY_FIFO: assert property (
        deep_sel && duty_cycled
        |=> !fifo_enable_out)
        else $error("FIFO reachable while duty-cycled under deep profile.");
    AST_DEEP_CUT_ON: assert property (
        deep_sel && (duty_cycled || halted)
        |=> deep_power_cut_out)
        else $error("Deep power cut missing.");
    AST_LIGHT_NO_CUT: assert property (
        !deep_sel
        |=> !deep_power_cut_out)
        else $error("Deep power cut under light profile.");
    AST_FULL_NO_CUT: assert property (
        !duty_cycled
        |=> !duty_power_cut_out)
        else $error("Duty power cut outside duty cycling.");
    AST_GAP_DROP: assert property (
        deep_sel && (duty_cycled || halted) && write_in && gap_reg != 8'h00
        |=> write_dropped_out)
        else $error("Early write not refused.");
    AST_GAP_OPEN: assert property (
        deep_sel && (duty_cycled || halted) && write_in && gap_reg == 8'h00
        |=> !write_dropped_out)
        else $error("Spaced write refused.");
    AST_DROP_KEEPS: assert property (
        write_in && !write_ok
        |=> $stable(profile_reg) && $stable(output_reg))
        else $error("Refused write changed a register.");
    AST_LIGHT_NO_DROP: assert property (
        !deep_sel && write_in
        |=> !write_dropped_out)
        else $error("Write refused under light profile.");

    // ------------------------------------------------------------------
    // Read path and output selection checks.
    // ------------------------------------------------------------------
    AST_READ_IDLE: assert property (
        !read_in
        |=> rdata_out == 8'h00)
        else $error("Read data outside a read cycle.");
    AST_X_HIGH_READ: assert property (
        read_in && addr_in == `OFS_DATA_X_HIGH
        |=> rdata_out == $past(high_bytes[0]))
        else $error("X high byte read wrong.");
    AST_FILTERED: assert property (
        !output_reg[`BIT_UNFILTERED_SELECT] && take
        |=> low_bytes[0] == $past(filtered_in[7:0]))
        else $error("Filtered sample not latched.");
    AST_UNFILTERED: assert property (
        output_reg[`BIT_UNFILTERED_SELECT] && take
        |=> low_bytes[2] == $past(unfiltered_in[39:32]))
        else $error("Unfiltered sample not latched.");
    AST_LOCK_OFF: assert property (
        output_reg[`BIT_LOCK_DISABLE] && take
        |=> high_bytes[1] == $past(sample_sel[31:24]))
        else $error("High byte held with lock disabled.");
endmodule

// >>> tb/host_bus_model.sv
`timescale 1ns/1ps
module host_bus_model #(
    parameter int GAP = 4
) (
    input  wire logic       clock_in,
    input  wire logic [7:0] rdata_in,
    output logic      [7:0] addr_out,
    output logic      [7:0] wdata_out,
    output logic            write_out,
    output logic            read_out
);
    initial begin
        addr_out  = 8'h00;
        wdata_out = 8'h00;
        write_out = 1'b0;
        read_out  = 1'b0;
    end

    // ------------------------------------------------------------------
    // Register accesses
    // ------------------------------------------------------------------
    // The strobe stays up so that accesses can follow with no gap.
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_in);
        addr_out  <= a;
        wdata_out <= d;
        write_out <= 1'b1;
        read_out  <= 1'b0;
    endtask

    task automatic idle();
        @(posedge clock_in);
        write_out <= 1'b0;
        read_out  <= 1'b0;
    endtask

    // A configuration write that is safe under every profile.
    task automatic slow_write(input logic [7:0] a, input logic [7:0] d);
        write_reg(a, d & ((a == 8'h12) ? 8'h60 : 8'hC0));
        idle();
        repeat (GAP + 1) @(posedge clock_in);
        #1;
    endtask

    task automatic read_reg(input logic [7:0] a, output logic [7:0] v);
        @(posedge clock_in);
        addr_out  <= a;
        read_out  <= 1'b1;
        write_out <= 1'b0;
        @(posedge clock_in);
        read_out <= 1'b0;
        #1 v = rdata_in;
    endtask
endmodule

// >>> tb/test_sleep_output_regs.sv
`timescale 1ns/1ps
module test_sleep_output_regs;
    localparam int          PERIOD = 8;
    localparam int          GAP    = 4;
    localparam logic [47:0] A      = 48'h665544332211;
    localparam logic [47:0] B      = 48'hCCBBAA998877;
    localparam logic [47:0] U      = 48'h0F0E0D0C0B0A;
    localparam logic [47:0] U2     = 48'h1F1E1D1C1B1A;
    logic        clock_in  = 1'b0;
    logic        nrst_in   = 1'b0;
    logic [7:0]  addr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic        write;
    logic        read;
    logic [1:0]  run_state = 2'h0;
    logic        event_in  = 1'b0;
    logic [47:0] filt      = 48'h0;
    logic [47:0] unfilt    = 48'h0;
    logic        fifo_req  = 1'b1;
    logic        fifo_en;
    logic        deep_cut;
    logic        duty_cut;
    logic        take;
    logic        dropped;
    int          fails      = 0;
    int          n_compared = 0;
    int          cycles     = 0;
    int          takes      = 0;
    int          n;

    sleep_output_regs #(.SAMPLE_PERIOD(PERIOD), .WRITE_GAP(GAP)) sleep_output_regs_inst (
        .clock_in(clock_in), .nrst_in(nrst_in), .addr_in(addr), .wdata_in(wdata),
        .write_in(write), .read_in(read), .rdata_out(rdata), .run_state_in(run_state),
        .sample_event_in(event_in), .filtered_in(filt), .unfiltered_in(unfilt),
        .fifo_request_in(fifo_req), .fifo_enable_out(fifo_en),
        .deep_power_cut_out(deep_cut), .duty_power_cut_out(duty_cut),
        .sample_take_out(take), .write_dropped_out(dropped)
    );

    host_bus_model #(.GAP(GAP)) host_bus_model_inst (
        .clock_in(clock_in), .rdata_in(rdata), .addr_out(addr), .wdata_out(wdata),
        .write_out(write), .read_out(read)
    );

    always #50 clock_in = ~clock_in;

    always @(posedge clock_in) begin
        cycles++;
        if (take === 1'b1) begin
            takes++;
        end
        if (cycles == 20000) begin
            fails++;
            print_verdict();
        end
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic print_verdict();
        if (fails == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic expect_reg(input string name, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        host_bus_model_inst.read_reg(a, v);
        check(name, {8'h00, v}, {8'h00, exp});
    endtask

    task automatic set_run(input logic [1:0] s);
        @(posedge clock_in);
        run_state <= s;
        repeat (6) @(posedge clock_in);
        #1;
    endtask

    task automatic take_sample(input logic [47:0] f, input logic [47:0] u);
        @(posedge clock_in);
        filt     <= f;
        unfilt   <= u;
        event_in <= 1'b1;
        @(posedge clock_in);
        event_in <= 1'b0;
        repeat (3) @(posedge clock_in);
        #1;
    endtask

    task automatic wait_take(output int k);
        k = 0;
        while (k < 40) begin
            @(posedge clock_in);
            k++;
            if (take === 1'b1) begin
                break;
            end
        end
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic test_reset_values();
        expect_reg("profile_reset", 8'h12, 8'h00);
        expect_reg("output_reset", 8'h13, 8'h00);
        host_bus_model_inst.write_reg(8'h12, 8'hFF);
        host_bus_model_inst.write_reg(8'h13, 8'hFF);
        host_bus_model_inst.idle();
        expect_reg("profile_reserved", 8'h12, 8'h60);
        expect_reg("output_reserved", 8'h13, 8'hC0);
        expect_reg("unmapped", 8'hFF, 8'h00);
    endtask

    task automatic test_profiles();
        host_bus_model_inst.slow_write(8'h12, 8'h40);
        set_run(2'h1);
        check("light_fifo", {15'h0, fifo_en}, 16'h0001);
        check("light_duty_cut", {15'h0, duty_cut}, 16'h0001);
        check("light_deep_cut", {15'h0, deep_cut}, 16'h0000);
        set_run(2'h2);
        host_bus_model_inst.slow_write(8'h12, 8'h00);
        check("deep_fifo", {15'h0, fifo_en}, 16'h0000);
        check("deep_cut", {15'h0, deep_cut}, 16'h0001);
        expect_reg("status_halted", 8'h20, 8'h04);
    endtask

    task automatic test_write_gap();
        host_bus_model_inst.write_reg(8'h13, 8'h80);
        host_bus_model_inst.write_reg(8'h13, 8'h00);
        host_bus_model_inst.idle();
        #1 check("drop_pulse", {15'h0, dropped}, 16'h0001);
        expect_reg("drop_keeps", 8'h13, 8'h80);
        host_bus_model_inst.slow_write(8'h13, 8'h00);
        expect_reg("slow_taken", 8'h13, 8'h00);
        set_run(2'h0);
        host_bus_model_inst.slow_write(8'h12, 8'h40);
        set_run(2'h1);
        host_bus_model_inst.write_reg(8'h13, 8'h80);
        host_bus_model_inst.write_reg(8'h13, 8'h40);
        host_bus_model_inst.idle();
        #1 check("fast_no_drop", {15'h0, dropped}, 16'h0000);
        expect_reg("fast_taken", 8'h13, 8'h40);
    endtask

    task automatic test_timebase();
        set_run(2'h0);
        host_bus_model_inst.slow_write(8'h12, 8'h20);
        set_run(2'h1);
        wait_take(n);
        wait_take(n);
        check("equal_period", n[15:0], PERIOD[15:0]);
        set_run(2'h0);
        host_bus_model_inst.slow_write(8'h12, 8'h00);
        set_run(2'h1);
        takes = 0;
        repeat (30) @(posedge clock_in);
        #1 check("event_idle", takes[15:0], 16'h0000);
        take_sample(A, U);
        check("event_take", takes[15:0], 16'h0001);
    endtask

    task automatic test_output_lock();
        set_run(2'h0);
        host_bus_model_inst.slow_write(8'h13, 8'h00);
        take_sample(A, U);
        expect_reg("x_low_filtered", 8'h02, 8'h11);
        take_sample(B, U);
        expect_reg("y_low", 8'h04, 8'h99);
        expect_reg("y_high", 8'h05, 8'hAA);
        expect_reg("x_high_frozen", 8'h03, 8'h22);
        take_sample(B, U);
        expect_reg("x_high_released", 8'h03, 8'h88);
        host_bus_model_inst.slow_write(8'h13, 8'hC0);
        take_sample(A, U);
        expect_reg("x_low_unfiltered", 8'h02, 8'h0A);
        expect_reg("z_high_unfiltered", 8'h07, 8'h0F);
        take_sample(A, U2);
        expect_reg("x_high_unlocked", 8'h03, 8'h1B);
    endtask

    initial begin
        repeat (8) @(posedge clock_in);
        nrst_in <= 1'b1;
        @(posedge clock_in);
        test_reset_values();
        test_profiles();
        test_write_gap();
        test_timebase();
        test_output_lock();
        print_verdict();
    end
endmodule
